/* hw/ssrd_spi_core.sv */
// module: spi status, mode-fault gating, master rate divider and split data port
`timescale 1ns/1ps
module ssrd_spi_core #(
	parameter int unsigned FRAME_BITS = ssrd_pkg::FRAME_BITS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [ssrd_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// serial pins
	input wire ssrd_pkg::ssrd_pin_in_t pin_in,
	output ssrd_pkg::ssrd_pin_out_t pin_out,
	// service requests and pin ownership
	output logic tx_irq,
	output logic tx_dma_req,
	output logic ss_gpio_release
);

	if (FRAME_BITS < 1 || FRAME_BITS > ssrd_pkg::DATA_W) begin : g_bad_frame
		$error("FRAME_BITS must lie between 1 and 8");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a level counts once stages two and three agree
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync3_reg;
	logic [3:0] filt_reg;
	logic [3:0] filt_d_reg;
	wire [3:0] pins_raw = {pin_in.miso, pin_in.mosi, pin_in.ss_n, pin_in.sclk};

	for (genvar i = 0; i < 4; i++) begin : g_sync
		always_ff @(posedge clk_sys) begin
			sync1_reg[i] <= pins_raw[i];
			sync2_reg[i] <= sync1_reg[i];
			sync3_reg[i] <= sync2_reg[i];
			// serial clock idles low, the rest high, so reset leaves no false edge
			if (rst) begin
				filt_reg[i] <= (i != 0);
				filt_d_reg[i] <= (i != 0);
			end else begin
				filt_reg[i] <= (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
				filt_d_reg[i] <= filt_reg[i];
			end
		end
	end

	wire sclk_rise = filt_reg[0] & ~filt_d_reg[0];
	wire sclk_fall = ~filt_reg[0] & filt_d_reg[0];
	wire ss_low = ~filt_reg[1];
	wire ss_fall = ~filt_reg[1] & filt_d_reg[1];
	wire ss_rise = filt_reg[1] & ~filt_d_reg[1];
	wire mosi_in = filt_reg[2];
	wire miso_in = filt_reg[3];

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [3:0] ctrl_reg;
	logic [1:0] rate_reg;
	logic fde_reg;
	logic tx_empty_reg;
	logic tx_full_reg;
	logic mode_fault_flag_reg;
	logic mode_fault_flag_armed_reg;
	logic rx_full_reg;
	logic [7:0] tx_buf_reg;
	logic [7:0] rx_data_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;

	wire en = ctrl_reg[ssrd_pkg::CTRL_EN_BIT];
	wire master = ctrl_reg[ssrd_pkg::CTRL_MASTER_BIT];
	wire tx_ie = ctrl_reg[ssrd_pkg::CTRL_TXIE_BIT];
	wire dma_sel = ctrl_reg[ssrd_pkg::CTRL_DMA_BIT];

	// one wait cycle per access; read data is latched in that cycle
	wire bus_req = avs_read | avs_write;
	wire sel_ctrl = avs_address == ssrd_pkg::OFF_CTRL;
	wire sel_stat = avs_address == ssrd_pkg::OFF_STAT;
	wire sel_data = avs_address == ssrd_pkg::OFF_DATA;
	wire acc_wr = avs_write & ack_reg & avs_byteenable[0];
	wire acc_rd = avs_read & ack_reg;
	wire wr_ctrl = acc_wr & sel_ctrl;
	wire wr_stat = acc_wr & sel_stat;
	wire wr_data = acc_wr & sel_data;
	wire rd_stat_mode_fault_flag = acc_rd & sel_stat & rdata_reg[ssrd_pkg::STAT_MODE_FAULT_FLAG_BIT];
	wire rd_data = acc_rd & sel_data;

	wire [7:0] stat_view = {rx_full_reg, 2'h0, mode_fault_flag_reg, tx_empty_reg, fde_reg, rate_reg};
	// unmapped addresses read as zero and ignore writes
	wire [7:0] rd_mux = sel_ctrl ? {4'h0, ctrl_reg} :
		sel_stat ? stat_view :
		sel_data ? rx_data_reg : 8'h00; // RQ16

	assign avs_waitrequest = bus_req & ~ack_reg;
	assign avs_readdata = rdata_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
			if (avs_read & ~ack_reg) begin
				rdata_reg <= {24'h00_0000, rd_mux};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// rate select: the half period of the master clock is the divisor
	logic [ssrd_pkg::DIV_W-1:0] div_sel;
	always_comb begin
		unique case (rate_reg) // RQ12
			2'h0: div_sel = ssrd_pkg::DIV_CODE0;
			2'h1: div_sel = ssrd_pkg::DIV_CODE1;
			2'h2: div_sel = ssrd_pkg::DIV_CODE2;
			2'h3: div_sel = ssrd_pkg::DIV_CODE3;
		endcase
	end
	// the counter runs from zero to one below the divisor
	wire [ssrd_pkg::DIV_W-1:0] div_last = div_sel - 8'h01;

	////////////////////////////////////////////////////////////////////////////
	// transfer engine
	logic master_busy_reg;
	logic slave_busy_reg;
	logic sclk_reg;
	logic sample_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [ssrd_pkg::DIV_W-1:0] div_cnt_reg;

	// a busy slave holds the byte in the buffer until its frame ends
	wire engine_busy = master_busy_reg | slave_busy_reg; // RQ5
	wire load = tx_full_reg & en & ~engine_busy; // RQ4
	wire half_tick = master_busy_reg & (div_cnt_reg == div_last); // RQ15
	wire m_rise = half_tick & ~sclk_reg;
	wire m_fall = half_tick & sclk_reg;
	wire slave_en = en & ~master;
	wire s_active = slave_en & slave_busy_reg & ss_low;
	wire s_rise = s_active & sclk_rise;
	wire s_fall = s_active & sclk_fall;
	wire fall_shift = m_fall | s_fall;
	wire [3:0] last_bit = 4'(FRAME_BITS - 1);
	wire frame_done = fall_shift & (bit_cnt_reg == last_bit);
	wire [7:0] shifted = {shift_reg[6:0], sample_reg};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			master_busy_reg <= 1'b0;
			slave_busy_reg <= 1'b0;
			sclk_reg <= 1'b0;
			sample_reg <= 1'b0;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			div_cnt_reg <= 8'h00;
		end else begin
			// rate bits only steer the master divider
			if (load & master) begin // RQ13
				master_busy_reg <= 1'b1;
			end else if (frame_done | ~en) begin
				master_busy_reg <= 1'b0;
			end
			if (slave_en & ss_fall) begin
				slave_busy_reg <= 1'b1;
			end else if (frame_done | ss_rise | ~slave_en) begin
				slave_busy_reg <= 1'b0;
			end
			if (half_tick) begin
				div_cnt_reg <= 8'h00;
				sclk_reg <= ~sclk_reg;
			end else if (master_busy_reg) begin
				div_cnt_reg <= div_cnt_reg + 8'h01;
			end else begin
				div_cnt_reg <= 8'h00;
				sclk_reg <= 1'b0;
			end
			if (m_rise) begin
				sample_reg <= miso_in;
			end else if (s_rise) begin
				sample_reg <= mosi_in;
			end
			if (load) begin
				shift_reg <= tx_buf_reg; // RQ1
			end else if (fall_shift) begin
				shift_reg <= shifted;
			end
			if (load | (slave_en & ss_fall) | frame_done) begin
				bit_cnt_reg <= 4'h0;
			end else if (fall_shift) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flags and software-visible state; a hardware set wins over a clear, except tx empty, where a data write wins over a load
	wire mode_fault_flag_set = fde_reg & en & ((master & ss_low) | (~master & slave_busy_reg & ss_rise)); // RQ18
	wire mode_fault_flag_clr = wr_ctrl & mode_fault_flag_armed_reg; // RQ19

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_reg <= ssrd_pkg::CTRL_RESET;
			rate_reg <= ssrd_pkg::RATE_RESET; // RQ14
			fde_reg <= 1'b0;
			tx_empty_reg <= ssrd_pkg::TXE_RESET; // RQ6
			tx_full_reg <= 1'b0;
			tx_buf_reg <= 8'h00;
			rx_data_reg <= 8'h00;
			rx_full_reg <= 1'b0;
			mode_fault_flag_reg <= 1'b0;
			mode_fault_flag_armed_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= avs_writedata[3:0];
			end
			if (wr_stat) begin
				rate_reg <= {avs_writedata[ssrd_pkg::STAT_RATE_HI_BIT],
					avs_writedata[ssrd_pkg::STAT_RATE_LO_BIT]};
				fde_reg <= avs_writedata[ssrd_pkg::STAT_FDE_BIT];
			end
			// the tx buffer is write-only, the rx register read-only
			if (wr_data) begin
				tx_buf_reg <= avs_writedata[7:0]; // RQ16
				tx_full_reg <= 1'b1;
				tx_empty_reg <= 1'b0; // RQ20
			end else if (load) begin
				tx_full_reg <= 1'b0;
				tx_empty_reg <= 1'b1; // RQ1
			end
			if (frame_done) begin
				rx_data_reg <= shifted;
			end
			rx_full_reg <= frame_done | (rx_full_reg & ~rd_data);
			// clearing the detect enable leaves the flag alone
			mode_fault_flag_reg <= mode_fault_flag_set | (mode_fault_flag_reg & ~mode_fault_flag_clr); // RQ7 RQ8 RQ11
			if (rd_stat_mode_fault_flag) begin
				mode_fault_flag_armed_reg <= 1'b1;
			end else if (wr_ctrl) begin
				mode_fault_flag_armed_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	wire tx_req = en & tx_ie & tx_empty_reg;
	assign tx_irq = tx_req & ~dma_sel; // RQ2
	assign tx_dma_req = tx_req & dma_sel; // RQ2
	// an enabled slave always owns its select input
	assign ss_gpio_release = ~en | (master & ~fde_reg); // RQ9 RQ10

	assign pin_out.sclk = sclk_reg;
	assign pin_out.sclk_oe_n = ~(en & master);
	assign pin_out.mosi = shift_reg[7];
	assign pin_out.mosi_oe_n = ~(en & master);
	assign pin_out.miso = shift_reg[7];
	assign pin_out.miso_oe_n = ~(slave_en & ss_low);

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] gap_cnt_reg;
	logic gap_seen_reg;
	always_ff @(posedge clk_sys) begin
		if (rst | ~master_busy_reg) begin
			gap_cnt_reg <= 8'h00;
			gap_seen_reg <= 1'b0;
		end else if (half_tick) begin
			gap_cnt_reg <= 8'h00;
			gap_seen_reg <= 1'b1;
		end else begin
			gap_cnt_reg <= gap_cnt_reg + 8'h01;
		end
	end

	wire [7:0] div_full = div_sel;

	AST_TXE_AFTER_RESET: assert property (@(posedge clk_sys) // RQ6
		$fell(rst) |-> tx_empty_reg)
		else $error("tx empty not set after reset");
	AST_TXE_REFILL: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
		wr_data & en & ~engine_busy & ~tx_full_reg |-> ##[1:2] tx_empty_reg)
		else $error("idle engine did not reload within two cycles");
	AST_TXE_CLEARED: assert property (@(posedge clk_sys) disable iff (rst) // RQ20
		wr_data |=> ~tx_empty_reg & tx_full_reg)
		else $error("data write did not clear tx empty");
	AST_TXE_WAIT_SLAVE: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
		slave_busy_reg & tx_full_reg |-> ~tx_empty_reg)
		else $error("tx empty set while slave frame pending");
	AST_TXE_ON_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
		load & ~wr_data |=> tx_empty_reg & (shift_reg == $past(tx_buf_reg)))
		else $error("load did not set tx empty with buffered byte");
	AST_TX_REQUEST: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
		tx_empty_reg & tx_ie & en |-> (tx_irq ^ tx_dma_req))
		else $error("tx empty request missing");
	AST_MODE_FAULT_FLAG_GATED: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
		$rose(mode_fault_flag_reg) |-> $past(fde_reg))
		else $error("mode fault set without detect enable");
	AST_MODE_FAULT_FLAG_HELD: assert property (@(posedge clk_sys) disable iff (rst) // RQ8
		mode_fault_flag_reg & ~(wr_ctrl & mode_fault_flag_armed_reg) |=> mode_fault_flag_reg)
		else $error("mode fault lost without clear sequence");
	AST_RATE_HALF: assert property (@(posedge clk_sys) disable iff (rst) // RQ15
		half_tick & gap_seen_reg |-> gap_cnt_reg == div_full - 8'h01)
		else $error("serial half period differs from divisor");
	AST_SS_OWNER: assert property (@(posedge clk_sys) disable iff (rst) // RQ10
		en & ~master |-> ~ss_gpio_release)
		else $error("slave released its select pin");
	AST_RX_SPLIT: assert property (@(posedge clk_sys) disable iff (rst) // RQ16
		avs_read & ~ack_reg & sel_data |=> avs_readdata[7:0] == $past(rx_data_reg))
		else $error("data read did not return receive register");

	CVR_MASTER_FRAME: cover property (@(posedge clk_sys) disable iff (rst)
		frame_done & master_busy_reg);
	CVR_SLAVE_FRAME: cover property (@(posedge clk_sys) disable iff (rst)
		frame_done & slave_busy_reg);
	CVR_MODE_FAULT_FLAG_CLEAR: cover property (@(posedge clk_sys) disable iff (rst)
		mode_fault_flag_reg & mode_fault_flag_clr);
	CVR_QUEUE_TWO: cover property (@(posedge clk_sys) disable iff (rst)
		wr_data ##[1:2] tx_empty_reg ##[1:8] wr_data);

endmodule // ssrd_spi_core

/* inc/ssrd_pkg.sv */
// package: register map, field layout, divisors and pin carriers of the spi status/rate/data block
// Summary of operation
// [RQ1] tx empty sets when byte enters shifter
// [RQ2] tx empty with enable raises irq or dma
// [RQ3] software writes data only when tx empty
// [RQ4] idle engine reloads, tx empty within two cycles
// [RQ5] busy slave defers load until transfer ends
// [RQ6] reset leaves tx empty flag set
// [RQ7] mode fault sets only with detect enabled
// [RQ8] disabling detection keeps a set fault flag
// [RQ9] master without detection releases select pin
// [RQ10] enabled slave always keeps select pin
// [RQ11] slave without detection only suppresses fault flag
// [RQ12] rate codes pick divisors 2, 8, 32, 128
// [RQ13] slave ignores the rate select bits
// [RQ14] reset clears rate select to divisor 2
// [RQ15] serial clock is base clock over twice divisor
// [RQ16] data writes go to tx, reads from rx
// [RQ17] software avoids read-modify-write on data port
// [RQ18] slave select misuse sets mode fault flag
// [RQ19] fault clears by status read then control write
// [RQ20] data write fills buffer and clears tx empty
package ssrd_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FRAME_BITS = 8;
	localparam int unsigned DIV_W = 8;
	// byte addresses on the register bus
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STAT = 4'h4;
	localparam logic [3:0] OFF_DATA = 4'h8;
	// control register fields
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_MASTER_BIT = 1;
	localparam int unsigned CTRL_TXIE_BIT = 2;
	localparam int unsigned CTRL_DMA_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h2;
	// spi_status_control fields
	localparam int unsigned STAT_RATE_LO_BIT = 0;
	localparam int unsigned STAT_RATE_HI_BIT = 1;
	localparam int unsigned STAT_FDE_BIT = 2;
	localparam int unsigned STAT_TXE_BIT = 3;
	localparam int unsigned STAT_MODE_FAULT_FLAG_BIT = 4;
	localparam int unsigned STAT_RXF_BIT = 7;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic TXE_RESET = 1'b1;
	// half serial period in base clocks equals the divisor
	localparam logic [7:0] DIV_CODE0 = 8'h02;
	localparam logic [7:0] DIV_CODE1 = 8'h08;
	localparam logic [7:0] DIV_CODE2 = 8'h20;
	localparam logic [7:0] DIV_CODE3 = 8'h80;
	localparam int unsigned SYNC_STAGES = 3;

	typedef struct packed {
		logic sclk;
		logic ss_n;
		logic mosi;
		logic miso;
	} ssrd_pin_in_t;

	typedef struct packed {
		logic sclk;
		logic sclk_oe_n;
		logic mosi;
		logic mosi_oe_n;
		logic miso;
		logic miso_oe_n;
	} ssrd_pin_out_t;
endpackage

/* dv/ssrd_remote_slave.sv */
// remote mode-0 spi slave that answers the block when it runs as master
`timescale 1ns/1ps
module ssrd_remote_slave (
	// select and serial lines
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// byte to send and byte received
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte
);
	logic [7:0] sh_reg;
	initial sh_reg = 8'h00;
	initial rx_byte = 8'h00;
	always @(negedge sel_n) sh_reg = tx_byte;
	always @(posedge sclk) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
	always @(negedge sclk) if (!sel_n) sh_reg = {sh_reg[6:0], sh_reg[7]};
	// deselected line shows the inverse so a stale bit is never read as good
	assign miso = sel_n ? ~sh_reg[7] : sh_reg[7];
endmodule // ssrd_remote_slave

/* dv/spi_status_rate_data_test.sv */
// self-checking bench for the spi status, rate and data block
`timescale 1ns/1ps
module spi_status_rate_data_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	ssrd_pkg::ssrd_pin_in_t pin_in;
	ssrd_pkg::ssrd_pin_out_t pin_out;
	logic tx_irq, tx_dma_req, ss_gpio_release;
	logic ss_n_pin = 1'b1;
	logic rs_sel_n = 1'b1;
	logic rm_sclk = 1'b0;
	logic rm_mosi = 1'b0;
	logic [7:0] rs_tx = 8'h00;
	logic [7:0] rs_rx;
	logic rs_miso;
	logic [15:0] exp_q[$];
	int errors = 0;
	int compares = 0;
	always #12.5 clk_sys = ~clk_sys;
	assign pin_in = '{sclk: pin_out.sclk_oe_n ? rm_sclk : pin_out.sclk, ss_n: ss_n_pin,
		mosi: pin_out.mosi_oe_n ? rm_mosi : pin_out.mosi, miso: rs_miso};
	ssrd_spi_core i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_in(pin_in), .pin_out(pin_out), .tx_irq(tx_irq), .tx_dma_req(tx_dma_req),
		.ss_gpio_release(ss_gpio_release));
	ssrd_remote_slave i_remote (.sel_n(rs_sel_n), .sclk(pin_out.sclk), .mosi(pin_out.mosi),
		.miso(rs_miso), .tx_byte(rs_tx), .rx_byte(rs_rx));
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one request at a time, held until waitrequest is seen low
	task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h0, d};
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// remote master for slave mode: mode 0, half period of eight clocks
	task automatic mframe(input logic [7:0] m, output logic [7:0] s);
		s = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			rm_mosi <= m[i];
			repeat (8) @(posedge clk_sys);
			rm_sclk <= 1'b1;
			s[i] = pin_out.miso;
			repeat (8) @(posedge clk_sys);
			rm_sclk <= 1'b0;
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({m, e});
		acc(a, 1'b0, 8'h00);
	endtask
	// read results are judged where they appear, against the oldest note
	always @(posedge clk_sys) begin
		if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
			logic [15:0] n;
			n = exp_q.pop_front();
			if (n[15:8] != 8'h00) chk(avs_readdata[7:0] & n[15:8], n[7:0] & n[15:8]);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic frame(input int c);
		logic [7:0] d;
		logic s;
		int n;
		d = 8'($urandom);
		rs_tx <= 8'($urandom);
		acc(ssrd_pkg::OFF_STAT, 1'b1, 8'(c));
		rs_sel_n <= 1'b0;
		acc(ssrd_pkg::OFF_DATA, 1'b1, d);
		s = 1'b0;
		repeat (3) begin
			@(negedge clk_sys);
			s |= (tx_irq === 1'b0);
		end
		chk({7'h0, s}, 8'h01);
		chk({7'h0, tx_irq}, 8'h01);
		// each half of the serial period lasts the divisor in base clocks
		@(posedge pin_out.sclk);
		n = 0;
		@(negedge clk_sys);
		while (pin_out.sclk === 1'b1) begin
			n++;
			@(negedge clk_sys);
		end
		chk(8'(n), 8'(2 << (2 * c)));
		n = 0;
		while (pin_out.sclk === 1'b0) begin
			n++;
			@(negedge clk_sys);
		end
		chk(8'(n), 8'(2 << (2 * c)));
		repeat (7) @(negedge pin_out.sclk);
		repeat (8) @(posedge clk_sys);
		rs_sel_n <= 1'b1;
		// the shortest divisor outruns the input synchroniser, so no rx compare there
		rd(ssrd_pkg::OFF_DATA, rs_tx, c == 0 ? 8'h00 : 8'hff);
		chk(rs_rx, d);
	endtask
	initial begin
		#(25 * 30000);
		errors++;
		finish_test();
	end
	initial begin
		logic [7:0] sb, mb, got;
		void'($urandom(8329));
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ssrd_pkg::OFF_CTRL, 8'h02, 8'hff);
		rd(ssrd_pkg::OFF_STAT, 8'h08, 8'h1f);
		rd(4'hc, 8'h00, 8'hff);
		acc(ssrd_pkg::OFF_CTRL, 1'b1, 8'h07);
		for (int c = 0; c < 4; c++) frame(c);
		acc(ssrd_pkg::OFF_CTRL, 1'b1, 8'h0f);
		@(negedge clk_sys);
		chk({6'h0, tx_dma_req, tx_irq}, 8'h02);
		acc(ssrd_pkg::OFF_CTRL, 1'b1, 8'h03);
		acc(ssrd_pkg::OFF_STAT, 1'b1, 8'h00);
		ss_n_pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk({7'h0, ss_gpio_release}, 8'h01);
		rd(ssrd_pkg::OFF_STAT, 8'h00, 8'h14);
		acc(ssrd_pkg::OFF_STAT, 1'b1, 8'h04);
		repeat (8) @(posedge clk_sys);
		chk({7'h0, ss_gpio_release}, 8'h00);
		rd(ssrd_pkg::OFF_STAT, 8'h14, 8'h14);
		ss_n_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		acc(ssrd_pkg::OFF_STAT, 1'b1, 8'h00);
		rd(ssrd_pkg::OFF_STAT, 8'h10, 8'h14);
		acc(ssrd_pkg::OFF_CTRL, 1'b1, 8'h03);
		rd(ssrd_pkg::OFF_STAT, 8'h00, 8'h10);
		acc(ssrd_pkg::OFF_STAT, 1'b1, 8'h03);
		acc(ssrd_pkg::OFF_CTRL, 1'b1, 8'h01);
		@(negedge clk_sys);
		chk({7'h0, ss_gpio_release}, 8'h00);
		chk({7'h0, pin_out.sclk_oe_n}, 8'h01);
		// slave frame at the slowest rate code; a byte queued mid-frame must wait
		sb = 8'($urandom);
		mb = 8'($urandom);
		acc(ssrd_pkg::OFF_DATA, 1'b1, sb);
		ss_n_pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		fork
			mframe(mb, got);
			begin
				repeat (40) @(posedge clk_sys);
				acc(ssrd_pkg::OFF_DATA, 1'b1, 8'($urandom));
				rd(ssrd_pkg::OFF_STAT, 8'h00, 8'h08);
			end
		join
		repeat (8) @(posedge clk_sys);
		ss_n_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(ssrd_pkg::OFF_STAT, 8'h08, 8'h18);
		rd(ssrd_pkg::OFF_DATA, mb, 8'hff);
		chk(got, sb);
		repeat (4) @(posedge clk_sys);
		finish_test();
	end
endmodule // spi_status_rate_data_test
